/* File: hw/sensor_frontend_config_regs.sv */
// sensor front-end configuration registers with shadow copy and monitors
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ns
//
// Behaviour
// - diagnostic alarm drives output to low or high level per select bit
// - two-bit protocol field picks one-wire, PWM, analog or SENT
// - store keeps reserved bits; shadow copy takes only defined bits
// - slope sources switch on in five steps, 435 or 580 ns apart; code rounds up to 5 or 6 clocks (500 or 600 ns)
// - oversampling field gives 4, 8, 16 or 32 samples per channel
// - five-bit excitation trim spans minimum to maximum current
// - gain timing field is zero-indexed sample number
// - gain field is fixed gain when automatic gain off
// - automatic gain starts at stage 3, clamped by gain field
// - gain mode selects integration and gain adaptation
// - integration time is seven plus stretch excitation periods
// - alarm when coil frequency above selected high limit
// - alarm when coil frequency below selected low limit
// - frequency measured over about 100 us before comparing
// - magnitude limits map codes to 55..90 and 20..55 percent
// - automatic gain compares magnitude with upper and lower limits
module sensor_frontend_config_regs #(
	parameter int FWIN_CYCLES = sfcfg_pkg::FWIN_CYC
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// avalon-mm slave
	input wire logic [9:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// sensor events and measurements
	input wire logic diag_alarm_i,
	input wire logic pwm_fall_i,
	input wire logic coil_clk_i,
	input wire logic mag_valid_i,
	input wire logic [6:0] mag_pct_i,
	// configuration outputs
	output sfcfg_pkg::cfg_out_s cfg_o,
	output logic diag_out_o,
	output logic [sfcfg_pkg::SLOPE_STEPS-1:0] slope_en_o,
	output logic freq_alarm_o,
	output logic [3:0] gain_stage_o
);
	import sfcfg_pkg::*;

	// non-volatile words keep every bit, reserved ones too
	logic [15:0] nv_r [NV_WORDS];
	logic [15:0] out_r, trim_r, gtim_r, gmode_r;
	logic copy_busy_r;
	logic [1:0] copy_idx_r;
	logic copy_req_r;
	logic [31:0] rdata_nxt;
	logic ack_r;
	logic [7:0] idx;
	logic [15:0] wr16;
	logic [15:0] fcnt_r, fres_r;
	logic [31:0] wcnt_r;
	logic coil_s1_r, coil_s2_r, coil_s3_r;
	logic coil_rise;
	logic fhi_r, flo_r;
	logic fhi_nxt, flo_nxt;
	logic wr_take, rd_load;
	logic auto_on, auto_prev_r;
	logic [3:0] gain_cap;

	function automatic logic [15:0] def_mask(input logic [1:0] i);
		unique case (i)
			2'd0: def_mask = DEF_OUTPUT;
			2'd1: def_mask = DEF_TRIM;
			2'd2: def_mask = DEF_GTIM;
			2'd3: def_mask = DEF_GMODE;
		endcase
	endfunction : def_mask

	function automatic logic [6:0] upper_pct(input logic [2:0] c);
		upper_pct = 7'(MAG_BASE_PCT + MAG_STEP_PCT * 7'(c));
	endfunction : upper_pct

	function automatic logic [6:0] lower_pct(input logic [2:0] c);
		lower_pct = 7'(MAG_BASE_PCT - MAG_STEP_PCT * 7'(3'h7 - c));
	endfunction : lower_pct

	// limits are edge counts that assume the nominal window length
	function automatic logic [15:0] hi_limit(input logic [1:0] code);
		hi_limit = FHI_TAB[code];
	endfunction : hi_limit

	function automatic logic [15:0] lo_limit(input logic [1:0] code);
		lo_limit = FLO_TAB[code];
	endfunction : lo_limit

	assign idx = avs_address_i[9:2];
	assign wr16 = avs_writedata_i[15:0];

	// a write lands on the edge that ends its second cycle;
	// read data is loaded one edge earlier so it stands at that edge
	assign wr_take = avs_write_i & ack_r;
	assign rd_load = avs_read_i & ~ack_r;

	// bus: one wait cycle, answer on the second edge
	always_ff @(posedge mclk_i) begin
		if (!resetn_i)
			ack_r <= 1'b0;
		else
			ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
	end
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;

	// nonvolatile store writes
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			nv_r[0] <= RST_OUTPUT;
			nv_r[1] <= RST_TRIM;
			nv_r[2] <= RST_GTIM;
			nv_r[3] <= RST_GMODE;
		end else if (wr_take) begin
			if (idx >= IDX_OUTPUT && idx <= IDX_GMODE)
				nv_r[2'(idx - IDX_OUTPUT)] <= wr16;
		end
	end

	// copy request: reset start, or write of bit 0 of nv control
	always_ff @(posedge mclk_i) begin
		if (!resetn_i)
			copy_req_r <= 1'b1;
		else if (wr_take && idx == IDX_NVCTL && wr16[0])
			copy_req_r <= 1'b1;
		else if (copy_busy_r && copy_idx_r == NV_LAST)
			copy_req_r <= 1'b0;
	end

	// copy sequencer, one word per clock
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			copy_busy_r <= 1'b0;
			copy_idx_r <= 2'h0;
		end else if (!copy_busy_r) begin
			copy_busy_r <= copy_req_r;
			copy_idx_r <= 2'h0;
		end else begin
			copy_idx_r <= copy_idx_r + 2'h1;
			if (copy_idx_r == NV_LAST)
				copy_busy_r <= 1'b0;
		end
	end

	// shadow bank: printed defaults until the copy lands
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			out_r <= RST_OUTPUT & DEF_OUTPUT;
			trim_r <= RST_TRIM & DEF_TRIM;
			gtim_r <= RST_GTIM & DEF_GTIM;
			gmode_r <= RST_GMODE & DEF_GMODE;
		end else if (copy_busy_r) begin
			unique case (copy_idx_r)
				2'd0: out_r <= nv_r[0] & def_mask(2'd0);
				2'd1: trim_r <= nv_r[1] & def_mask(2'd1);
				2'd2: gtim_r <= nv_r[2] & def_mask(2'd2);
				2'd3: gmode_r <= nv_r[3] & def_mask(2'd3);
			endcase
		end
	end

	// read mux; shadow reads show masked values
	always_comb begin
		rdata_nxt = 32'h0;
		unique case (idx)
			IDX_OUTPUT: rdata_nxt[15:0] = out_r;
			IDX_TRIM: rdata_nxt[15:0] = trim_r;
			IDX_GTIM: rdata_nxt[15:0] = gtim_r;
			IDX_GMODE: rdata_nxt[15:0] = gmode_r;
			IDX_NVCTL: rdata_nxt[0] = copy_busy_r | copy_req_r;
			IDX_STAT: rdata_nxt[5:0] = {gain_stage_o, flo_r, fhi_r};
			IDX_FREQ: rdata_nxt[15:0] = fres_r;
			IDX_MAG: rdata_nxt[13:0] = {upper_pct(gmode_r[F_MUL_LO +: 3]),
				lower_pct(gmode_r[F_MLL_LO +: 3])};
			default: rdata_nxt = 32'h0;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i)
			avs_readdata_o <= 32'h0;
		else if (rd_load)
			avs_readdata_o <= rdata_nxt;
	end

	// decoded configuration, one cycle behind the shadow bank
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			cfg_o <= '0;
		end else begin
			cfg_o.proto <= out_r[F_PROTO_LO +: 2];
			cfg_o.diag_level <= (out_r[F_PROTO_LO +: 2] == PROTO_PWM) ?
				out_r[F_PWM_DIAG] : out_r[F_ANA_DIAG];
			cfg_o.exc_trim <= trim_r[F_LCCAL_LO +: 5];
			cfg_o.osr <= trim_r[F_OSR_LO +: 2];
			cfg_o.smpl_cycle <= gtim_r[F_SMPL_LO +: 6];
			cfg_o.gain_mode <= gmode_r[F_MODE_LO +: 2];
			cfg_o.integ_cycles <= INTEG_BASE + 6'(gtim_r[F_EXT_LO +: 5]);
		end
	end

	// alarm level follows the select bit of the active protocol
	always_ff @(posedge mclk_i) begin
		if (!resetn_i)
			diag_out_o <= 1'b0;
		else
			diag_out_o <= diag_alarm_i & cfg_o.diag_level;
	end

	slope_stepper u_slope (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.start_i(pwm_fall_i),
		.slope_time_i(trim_r[F_SLOPE_LO +: 2]),
		.src_en_o(slope_en_o)
	);

	// coil clock synchroniser and edge count
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			coil_s1_r <= 1'b0;
			coil_s2_r <= 1'b0;
			coil_s3_r <= 1'b0;
		end else begin
			coil_s1_r <= coil_clk_i;
			coil_s2_r <= coil_s1_r;
			coil_s3_r <= coil_s2_r;
		end
	end

	// third stage only delays the synchronised level for edge finding
	assign coil_rise = coil_s2_r & ~coil_s3_r;
	assign fhi_nxt = fcnt_r > hi_limit(gmode_r[F_FHI_LO +: 2]);
	assign flo_nxt = fcnt_r < lo_limit(gmode_r[F_FLO_LO +: 2]);

	// limits scaled: edges per window at 10 kHz resolution
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			wcnt_r <= 32'h0;
			fcnt_r <= 16'h0;
			fres_r <= 16'h0;
			fhi_r <= 1'b0;
			flo_r <= 1'b0;
			freq_alarm_o <= 1'b0;
		end else if (wcnt_r == 32'(FWIN_CYCLES - 1)) begin
			wcnt_r <= 32'h0;
			fcnt_r <= 16'h0;
			fres_r <= fcnt_r;
			fhi_r <= fhi_nxt;
			flo_r <= flo_nxt;
			freq_alarm_o <= fhi_nxt | flo_nxt;
		end else begin
			wcnt_r <= wcnt_r + 32'h1;
			// saturate so a runaway coil cannot wrap into range
			if (coil_rise && fcnt_r != 16'hffff)
				fcnt_r <= fcnt_r + 16'h1;
		end
	end

	// gain field: fixed stage when off, ceiling when regulating
	assign auto_on = gmode_r[F_MODE_LO + 1];
	assign gain_cap = gtim_r[F_GAIN_LO +: 4];

	// remember the mode so that entering automatic gain restarts it
	always_ff @(posedge mclk_i) begin
		if (!resetn_i)
			auto_prev_r <= 1'b0;
		else
			auto_prev_r <= auto_on;
	end

	// gain regulator
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			gain_stage_o <= GAIN_START;
		end else if (!auto_on) begin
			gain_stage_o <= gain_cap;
		end else if (!auto_prev_r) begin
			// start stage still obeys a lower ceiling
			gain_stage_o <= (gain_cap < GAIN_START) ? gain_cap : GAIN_START;
		end else if (gain_stage_o > gain_cap) begin
			gain_stage_o <= gain_cap;
		end else if (mag_valid_i) begin
			if (mag_pct_i > upper_pct(gmode_r[F_MUL_LO +: 3]) &&
				gain_stage_o != 4'h0)
				gain_stage_o <= gain_stage_o - 4'h1;
			else if (mag_pct_i < lower_pct(gmode_r[F_MLL_LO +: 3]) &&
				gain_stage_o < gain_cap)
				gain_stage_o <= gain_stage_o + 4'h1;
		end
	end
endmodule : sensor_frontend_config_regs

/* File: hw/sfcfg_pkg.sv */
// register offsets, field layouts and timing constants for the config bank
package sfcfg_pkg;
	// printed offsets are register indices; byte address = 4 * index
	localparam logic [7:0] IDX_OUTPUT = 8'h0a;
	localparam logic [7:0] IDX_TRIM = 8'h0b;
	localparam logic [7:0] IDX_GTIM = 8'h0c;
	localparam logic [7:0] IDX_GMODE = 8'h0d;
	localparam logic [7:0] IDX_NVCTL = 8'h20;
	localparam logic [7:0] IDX_STAT = 8'h21;
	localparam logic [7:0] IDX_FREQ = 8'h22;
	localparam logic [7:0] IDX_MAG = 8'h23;

	localparam logic [15:0] RST_OUTPUT = 16'h0802;
	localparam logic [15:0] RST_TRIM = 16'h8107;
	localparam logic [15:0] RST_GTIM = 16'h0836;
	localparam logic [15:0] RST_GMODE = 16'h0255;

	// defined-bit masks: only these reach the shadow bank
	localparam logic [15:0] DEF_OUTPUT = 16'h7f7f;
	localparam logic [15:0] DEF_TRIM = 16'hf1f7;
	localparam logic [15:0] DEF_GTIM = 16'h7fff;
	localparam logic [15:0] DEF_GMODE = 16'hff77;

	localparam int NV_WORDS = 4;
	localparam logic [1:0] NV_LAST = 2'h3;

	// field positions
	localparam int F_PROTO_LO = 0;
	localparam int F_ANA_DIAG = 2;
	localparam int F_PWM_DIAG = 3;
	localparam int F_OSR_LO = 12;
	localparam int F_SLOPE_LO = 14;
	localparam int F_LCCAL_LO = 4;
	localparam int F_GAIN_LO = 0;
	localparam int F_EXT_LO = 4;
	localparam int F_SMPL_LO = 9;
	localparam int F_MODE_LO = 12;
	localparam int F_FHI_LO = 10;
	localparam int F_FLO_LO = 8;
	localparam int F_MUL_LO = 4;
	localparam int F_MLL_LO = 0;

	typedef enum logic [1:0] {
		PROTO_ONEWIRE = 2'b00,
		PROTO_PWM = 2'b01,
		PROTO_ANALOG = 2'b10,
		PROTO_SENT = 2'b11
	} proto_e;

	localparam logic [3:0] GAIN_START = 4'h3;
	localparam logic [5:0] INTEG_BASE = 6'h07;
	localparam int SLOPE_STEPS = 5;

	// timing
	localparam int CLK_NS = 100;
	localparam int SLOPE0_NS = 435;
	localparam int SLOPE1_NS = 580;
	localparam int SLOPE0_CYC = (SLOPE0_NS + CLK_NS - 1) / CLK_NS;
	localparam int SLOPE1_CYC = (SLOPE1_NS + CLK_NS - 1) / CLK_NS;
	localparam int FWIN_US = 100;
	localparam int FWIN_CYC = FWIN_US * 1000 / CLK_NS;

	// limits in coil edges per window, 10 kHz units: edges = mhz*100
	localparam logic [15:0] FHI_TAB [4] = '{16'd600, 16'd650, 16'd700, 16'd800};
	localparam logic [15:0] FLO_TAB [4] = '{16'd100, 16'd150, 16'd200, 16'd250};
	localparam logic [6:0] MAG_BASE_PCT = 7'd55;
	localparam logic [6:0] MAG_STEP_PCT = 7'd5;

	typedef struct packed {
		logic [1:0] proto;
		logic diag_level;
		logic [4:0] exc_trim;
		logic [1:0] osr;
		logic [5:0] smpl_cycle;
		logic [1:0] gain_mode;
		logic [5:0] integ_cycles;
	} cfg_out_s;
endpackage : sfcfg_pkg

/* File: hw/slope_stepper.sv */
// pwm falling-edge slope current sequencer
`timescale 1ns/1ns
module slope_stepper (
	// clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// control
	input wire logic start_i,
	input wire logic [1:0] slope_time_i,
	// current source enables
	output logic [sfcfg_pkg::SLOPE_STEPS-1:0] src_en_o
);
	import sfcfg_pkg::*;
	logic [3:0] tick_r;
	logic [3:0] step_r;
	logic [3:0] ival;

	// only codes 0b00/0b01 have a printed interval; others use the longer
	assign ival = (slope_time_i == 2'b00) ? 4'(SLOPE0_CYC) : 4'(SLOPE1_CYC);

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			tick_r <= 4'h0;
			step_r <= 4'h0;
			src_en_o <= '0;
		end else if (start_i) begin
			tick_r <= 4'h1;
			step_r <= 4'h1;
			src_en_o <= SLOPE_STEPS'(1);
		end else if (step_r != 4'h0 && step_r < 4'(SLOPE_STEPS)) begin
			if (tick_r >= ival) begin
				tick_r <= 4'h1;
				step_r <= step_r + 4'h1;
				src_en_o <= {src_en_o[SLOPE_STEPS-2:0], 1'b1};
			end else begin
				tick_r <= tick_r + 4'h1;
			end
		end
	end
endmodule : slope_stepper

/* File: sim/sensor_frontend_config_regs_props.sv */
// port-level assertions for the config bank
`timescale 1ns/1ns
module sfcfg_props
	import sfcfg_pkg::*;
(
	// clock, reset and bus
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic [9:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	// events and outputs
	input wire logic diag_alarm_i,
	input wire cfg_out_s cfg_o,
	input wire logic diag_out_o,
	input wire logic [SLOPE_STEPS-1:0] slope_en_o,
	input wire logic [3:0] gain_stage_o
);
	logic [15:0] rd_mask;
	always_comb begin
		case (avs_address_i[9:2])
			IDX_OUTPUT: rd_mask = DEF_OUTPUT;
			IDX_TRIM: rd_mask = DEF_TRIM;
			IDX_GTIM: rd_mask = DEF_GTIM;
			IDX_GMODE: rd_mask = DEF_GMODE;
			IDX_NVCTL, IDX_STAT, IDX_FREQ, IDX_MAG: rd_mask = 16'hffff;
			default: rd_mask = 16'h0000;
		endcase
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	property p_wait;
		$rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o
			##1 !avs_waitrequest_o;
	endproperty
	a_wait: assert property (p_wait) else $error("wait cycle wrong");
	property p_rd_mask;
		avs_read_i && !avs_waitrequest_o
			|-> (avs_readdata_o & ~{16'h0000, rd_mask}) == 32'h0;
	endproperty
	a_rd_mask: assert property (p_rd_mask) else $error("bit not zero");
	property p_rd_stand;
		!(avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o);
	endproperty
	a_rd_stand: assert property (p_rd_stand) else $error("data moved");
	property p_diag;
		diag_out_o |-> $past(diag_alarm_i);
	endproperty
	a_diag: assert property (p_diag) else $error("diag without alarm");
	property p_step;
		$rose(slope_en_o[0]) |=> !slope_en_o[1] [*4] ##[1:2] slope_en_o[1];
	endproperty
	a_step: assert property (p_step) else $error("step interval");
	property p_thermo;
		(slope_en_o & 5'(slope_en_o + 1'b1)) == 5'h00;
	endproperty
	a_thermo: assert property (p_thermo) else $error("not in order");
	property p_gain_rst;
		$rose(resetn_i) |-> gain_stage_o == GAIN_START;
	endproperty
	a_gain_rst: assert property (p_gain_rst) else $error("gain start");
	property p_cfg_dflt;
		$rose(resetn_i) |=> cfg_o.proto == PROTO_ANALOG
			&& cfg_o.exc_trim == 5'h10 && cfg_o.osr == 2'b00;
	endproperty
	a_cfg_dflt: assert property (p_cfg_dflt) else $error("defaults");
endmodule : sfcfg_props

/* File: sim/test_sensor_frontend_config_regs.sv */
// self-checking bench for the config bank
`timescale 1ns/1ns
module test_sensor_frontend_config_regs;
	import sfcfg_pkg::*;
	localparam int FW = 2000;
	logic mclk_i = 0, resetn_i = 0, avs_read_i = 0, avs_write_i = 0;
	logic [9:0] avs_address_i = '0;
	logic [31:0] avs_writedata_i = '0, avs_readdata_o, d;
	logic avs_waitrequest_o, diag_out_o, freq_alarm_o;
	logic diag_alarm_i = 0, pwm_fall_i = 0, coil_clk_i = 0, mag_valid_i = 0;
	logic [6:0] mag_pct_i = '0;
	logic [15:0] v;
	cfg_out_s cfg_o;
	logic [4:0] slope_en_o;
	logic [3:0] gain_stage_o;
	int error_cnt = 0, checks = 0, coil_per = 0, coil_n = 0, n;
	logic [7:0] ix [4] = '{IDX_OUTPUT, IDX_TRIM, IDX_GTIM, IDX_GMODE};
	logic [15:0] rv [4] = '{RST_OUTPUT, RST_TRIM, RST_GTIM, RST_GMODE};
	logic [15:0] dm [4] = '{DEF_OUTPUT, DEF_TRIM, DEF_GTIM, DEF_GMODE};
	sensor_frontend_config_regs #(.FWIN_CYCLES(FW))
	u_sensor_frontend_config_regs (
		.mclk_i(mclk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .diag_alarm_i(diag_alarm_i),
		.pwm_fall_i(pwm_fall_i), .coil_clk_i(coil_clk_i),
		.mag_valid_i(mag_valid_i), .mag_pct_i(mag_pct_i), .cfg_o(cfg_o),
		.diag_out_o(diag_out_o), .slope_en_o(slope_en_o),
		.freq_alarm_o(freq_alarm_o), .gain_stage_o(gain_stage_o)
	);
	initial begin
		forever #50 mclk_i = ~mclk_i;
	end
	// coil stand-in: half period in clocks, zero stops it
	always @(posedge mclk_i) begin
		if (coil_per != 0 && ++coil_n >= coil_per) begin
			coil_n = 0;
			coil_clk_i <= ~coil_clk_i;
		end
	end
	task automatic tk(input int c);
		repeat (c) @(posedge mclk_i);
	endtask : tk
	task automatic chk(input string nm, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [15:0] wd);
		@(posedge mclk_i);
		avs_address_i <= {a, 2'b00};
		avs_writedata_i <= {16'h0000, wd};
		avs_read_i <= !w;
		avs_write_i <= w;
		do begin
			@(posedge mclk_i);
		end while (avs_waitrequest_o !== 1'b0);
		d = avs_readdata_o;
		avs_read_i <= 0;
		avs_write_i <= 0;
	endtask : bus
	// store contents only show after a copy
	task automatic cp;
		bus(1, IDX_NVCTL, 16'h0001);
		tk(10);
		bus(0, IDX_NVCTL, 16'h0000);
		chk("copy_done", d[0], 1'b0);
	endtask : cp
	task automatic wt(input int b);
		n = 0;
		while (slope_en_o[b] !== 1'b1 && n < 20) begin
			@(posedge mclk_i);
			n++;
		end
	endtask : wt
	task automatic report_and_stop;
		if (error_cnt == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	initial begin
		tk(40000);
		error_cnt++;
		report_and_stop;
	end
	initial begin
		tk(12);
		resetn_i <= 1;
		tk(10);
		for (int i = 0; i < 4; i++) begin
			bus(0, ix[i], 16'h0000);
			chk("dflt", d, 32'(rv[i] & dm[i]));
			bus(1, ix[i], 16'hffff);
			bus(0, ix[i], 16'h0000);
			chk("pre_copy", d, 32'(rv[i] & dm[i]));
		end
		cp;
		for (int i = 0; i < 4; i++) begin
			bus(0, ix[i], 16'h0000);
			chk("masked", d, 32'(dm[i]));
		end
		bus(1, 8'h30, 16'hffff);
		bus(0, 8'h30, 16'h0000);
		chk("unmapped", d, 32'h0);
		for (int p = 0; p < 8; p++) begin
			v = (p % 4 == 1) ? 16'h0004 : 16'h0008;
			if (p > 3)
				v = v ^ 16'h000c;
			bus(1, IDX_OUTPUT, v | 16'(p % 4));
			cp;
			diag_alarm_i <= 1;
			tk(3);
			chk("diag", diag_out_o, p > 3);
			chk("proto", cfg_o.proto, p % 4);
			diag_alarm_i <= 0;
		end
		for (int o = 0; o < 4; o++) begin
			bus(1, IDX_TRIM, 16'((o % 2) << 14 | o << 12 | (o == 3 ? 31 : o) << 4));
			cp;
			chk("osr", cfg_o.osr, o);
			chk("trim", cfg_o.exc_trim, o == 3 ? 31 : o);
			if (o == 1) begin
				pwm_fall_i <= 1;
				tk(1);
				pwm_fall_i <= 0;
				wt(0);
				wt(1);
				chk("step", n, SLOPE1_CYC);
			end
		end
		bus(1, IDX_GMODE, 16'h0000);
		cp;
		for (int f = 0; f < 3; f++) begin
			coil_per = f == 0 ? 1 : (f == 1 ? 5 : 0);
			tk(2 * FW + 20);
			chk("falarm", freq_alarm_o, f != 1);
			bus(0, IDX_STAT, 16'h0000);
			chk("fstat", d[1:0], f == 0 ? 1 : (f == 2 ? 2 : 0));
		end
		for (int c = 0; c < 8; c++) begin
			bus(1, IDX_GMODE, 16'(c << 4 | c));
			cp;
			bus(0, IDX_MAG, 16'h0000);
			chk("mag", d, 32'((55 + 5 * c) << 7 | (20 + 5 * c)));
		end
		bus(1, IDX_TRIM, 16'h1000);
		bus(1, IDX_GTIM, 16'h1835);
		cp;
		chk("smpl", cfg_o.smpl_cycle, 6'h0c);
		chk("integ", cfg_o.integ_cycles, INTEG_BASE + 6'h03);
		chk("fixed", gain_stage_o, 4'h5);
		for (int m = 0; m < 4; m++) begin
			bus(1, IDX_GMODE, 16'(m << 12));
			cp;
			chk("mode", cfg_o.gain_mode, m);
		end
		bus(1, IDX_GTIM, 16'h1834);
		bus(1, IDX_GMODE, 16'h2000);
		cp;
		chk("agc_start", gain_stage_o, GAIN_START);
		for (int k = 0; k < 6; k++) begin
			mag_valid_i <= 1;
			tk(1);
			mag_valid_i <= 0;
			tk(4);
		end
		chk("agc_clamp", gain_stage_o, 4'h4);
		report_and_stop;
	end
endmodule : test_sensor_frontend_config_regs
bind sensor_frontend_config_regs sfcfg_props u_sfcfg_props (
	.mclk_i(mclk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
	.diag_alarm_i(diag_alarm_i), .cfg_o(cfg_o), .diag_out_o(diag_out_o),
	.slope_en_o(slope_en_o), .gain_stage_o(gain_stage_o)
);
